// File: common/irqc_pkg.sv
// Package for interrupt and control register block
package irqc_pkg;
    // Data space offsets
    localparam logic [7:0] OFF_SERIAL_SHIFT_DATA  = 8'h00E9;
    localparam logic [7:0] OFF_TIMER_COUNT_LOW    = 8'h00EA;
    localparam logic [7:0] OFF_TIMER_COUNT_HIGH   = 8'h00EB;
    localparam logic [7:0] OFF_TIMER_RELOAD_LOW   = 8'h00EC;
    localparam logic [7:0] OFF_TIMER_RELOAD_HIGH  = 8'h00ED;
    localparam logic [7:0] OFF_TIMER_SERIAL_CTRL  = 8'h00EE;
    localparam logic [7:0] OFF_PROC_STATUS_WORD   = 8'h00EF;
    localparam logic [7:0] OFF_INDEX_POINTER_TWO  = 8'h00FC;
    localparam logic [7:0] OFF_STACK_POINTER      = 8'h00FD;
    localparam logic [7:0] OFF_INDEX_POINTER_ONE  = 8'h00FE;
    localparam logic [7:0] UNUSED_RAM_LO          = 8'h0030;
    localparam logic [7:0] UNUSED_RAM_HI          = 8'h007F;
    localparam logic [7:0] UNDEF_DATA             = 8'h0000;
    localparam logic [7:0] ALL_ONES               = 8'h00FF;
    // Program space
    localparam int         PC_W                   = 15;
    localparam logic [14:0] IRQ_VECTOR            = 15'h00FF;
    localparam logic [14:0] PROG_LIMIT            = 15'h0300;
    localparam logic [7:0] TRAP_OPCODE            = 8'h0000;
    // Status word bit positions
    localparam int PSW_GIE  = 0;
    localparam int PSW_ENI  = 1;
    localparam int PSW_BUSY = 2;
    localparam int PSW_EXT_PENDING = 3;
    localparam int PSW_TIMER_IRQ_ENABLE = 4;
    localparam int PSW_TIMER_PENDING = 5;
    localparam int PSW_C    = 6;
    localparam int PSW_HC   = 7;
    // Control register bit positions
    localparam int CTL_DIV_LOW  = 0;
    localparam int CTL_DIV_HIGH = 1;
    localparam int CTL_EDGE     = 2;
    localparam int CTL_PINSEL   = 3;
    localparam int CTL_GO       = 4;
    localparam int CTL_MODE_Z   = 5;
    localparam int CTL_MODE_B   = 6;
    localparam int CTL_MODE_A   = 7;
    localparam logic [7:0] RESET_CTRL = 8'h0000;
    localparam logic [7:0] RESET_PSW  = 8'h0000;
    localparam logic [7:0] RESET_REG  = 8'h0000;
    // Serial divide ratios
    localparam logic [3:0] DIV_BY_2 = 4'h2;
    localparam logic [3:0] DIV_BY_4 = 4'h4;
    localparam logic [3:0] DIV_BY_8 = 4'h8;
    // Carry flag operations
    typedef enum logic [1:0] {
        IRQC_CY_NONE = 2'h0,
        IRQC_CY_SET  = 2'h1,
        IRQC_CY_CLR  = 2'h2,
        IRQC_CY_LOAD = 2'h3
    } irqc_cy_op_t;
    // Core step request bundle
    typedef struct packed {
        logic        boundary;
        logic        fetch_valid;
        logic [7:0]  fetch_opcode;
        logic [14:0] fetch_pc;
        logic        irq_exit;
        logic [14:0] stack_pc;
    } irqc_core_req_t;
    // Data bus access bundle
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } irqc_data_req_t;
endpackage

// File: hw/irqc_top.sv
// Interrupt sequencing and control/status registers
`timescale 1ns/100ps
module irqc_top (
    input  wire logic                    sys_clk,
    input  wire logic                    nrst,
    input  wire irqc_pkg::irqc_core_req_t core_req,
    input  wire irqc_pkg::irqc_data_req_t data_req,
    input  wire logic [7:0]              ram_rdata,
    input  wire logic [7:0]              rom_rdata,
    input  wire logic [14:0]             rom_addr,
    input  wire logic                    ext_irq_pin,
    input  wire logic                    timer_underflow,
    input  wire logic                    timer_capture,
    input  wire logic                    serial_busy_set,
    input  wire logic                    serial_busy_clr,
    input  wire irqc_pkg::irqc_cy_op_t   carry_op,
    input  wire logic                    carry_in,
    input  wire logic                    half_in,
    output logic [7:0]                   rom_data_out,
    output logic [7:0]                   data_rdata,
    output logic                         vector_take,
    output logic [14:0]                  vector_pc,
    output logic                         push_req,
    output logic [14:0]                  push_pc,
    output logic                         trap_taken,
    output logic                         timer_advance,
    output logic [2:0]                   timer_mode,
    output logic [3:0]                   serial_divide,
    output logic                         serial_pins_on,
    output logic [7:0]                   control_word,
    output logic [7:0]                   status_word
);
    logic [7:0] ctrl;
    logic [7:0] processor_status_word;
    logic [7:0] serial_shift_data;
    logic [7:0] timer_count_low;
    logic [7:0] timer_count_high;
    logic [7:0] timer_reload_low;
    logic [7:0] timer_reload_high;
    logic [7:0] index_pointer_two;
    logic [7:0] stack_pointer;
    logic [7:0] index_pointer_one;
    logic [2:0] ext_sync;
    logic       ext_prev;
    logic       ext_edge;
    logic       hw_req;
    logic       trap_req;
    logic       accept_hw;
    logic       accept_trap;
    logic       wr_psw;
    logic       next_ext_pending;
    logic       next_timer_pending;

    function automatic logic wr_hit(input irqc_pkg::irqc_data_req_t r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction

    // Three-stage sync; edge seen once stage three and ext_prev differ in the direction CTL_EDGE selects
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ext_sync <= 3'h0;
            ext_prev <= 1'b0;
        end else begin
            ext_sync <= {ext_sync[1:0], ext_irq_pin};
            ext_prev <= ext_sync[2];
        end
    end

    always_comb begin
        if (ctrl[irqc_pkg::CTL_EDGE]) begin
            ext_edge = ext_sync[2] & ~ext_prev;
        end else begin
            ext_edge = ~ext_sync[2] & ext_prev;
        end
    end

    // Hardware requests gated by the global enable and the source's own enable
    assign hw_req = processor_status_word[irqc_pkg::PSW_GIE] &
        ((processor_status_word[irqc_pkg::PSW_ENI] & processor_status_word[irqc_pkg::PSW_EXT_PENDING]) |
         (processor_status_word[irqc_pkg::PSW_TIMER_IRQ_ENABLE] & processor_status_word[irqc_pkg::PSW_TIMER_PENDING]));
    // Trap ignores the global enable
    assign trap_req = core_req.fetch_valid &&
        (core_req.fetch_opcode == irqc_pkg::TRAP_OPCODE);
    // Enable cleared by a one-cycle instruction is still seen here this cycle
    assign accept_hw = core_req.boundary & hw_req;
    // Trap only when no hardware source is pending
    assign accept_trap = trap_req & ~accept_hw &
        ~processor_status_word[irqc_pkg::PSW_EXT_PENDING] & ~processor_status_word[irqc_pkg::PSW_TIMER_PENDING];
    assign wr_psw = wr_hit(data_req, irqc_pkg::OFF_PROC_STATUS_WORD);

    // Control register
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ctrl <= irqc_pkg::RESET_CTRL;
        end else if (wr_hit(data_req, irqc_pkg::OFF_TIMER_SERIAL_CTRL)) begin
            ctrl <= data_req.wdata;
        end
    end

    // Pending flags: hardware set beats software clear
    always_comb begin
        next_ext_pending = processor_status_word[irqc_pkg::PSW_EXT_PENDING];
        next_timer_pending = processor_status_word[irqc_pkg::PSW_TIMER_PENDING];
        if (wr_psw) begin
            next_ext_pending = data_req.wdata[irqc_pkg::PSW_EXT_PENDING];
            next_timer_pending = data_req.wdata[irqc_pkg::PSW_TIMER_PENDING];
        end
        if (ext_edge) begin
            next_ext_pending = 1'b1;
        end
        if (ctrl[irqc_pkg::CTL_MODE_A] && ctrl[irqc_pkg::CTL_MODE_B]) begin
            if (timer_capture) begin
                next_timer_pending = 1'b1;
            end
        end else if (timer_underflow) begin
            next_timer_pending = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            processor_status_word[irqc_pkg::PSW_EXT_PENDING] <= 1'b0;
            processor_status_word[irqc_pkg::PSW_TIMER_PENDING] <= 1'b0;
        end else begin
            processor_status_word[irqc_pkg::PSW_EXT_PENDING] <= next_ext_pending;
            processor_status_word[irqc_pkg::PSW_TIMER_PENDING] <= next_timer_pending;
        end
    end

    // Global enable: acceptance clears, exit sets, trap leaves alone
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            processor_status_word[irqc_pkg::PSW_GIE] <= 1'b0;
        end else if (accept_hw) begin
            processor_status_word[irqc_pkg::PSW_GIE] <= 1'b0;
        end else if (core_req.irq_exit) begin
            processor_status_word[irqc_pkg::PSW_GIE] <= 1'b1;
        end else if (wr_psw) begin
            processor_status_word[irqc_pkg::PSW_GIE] <= data_req.wdata[irqc_pkg::PSW_GIE];
        end
    end

    // Source enables and serial busy
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            processor_status_word[irqc_pkg::PSW_ENI] <= 1'b0;
            processor_status_word[irqc_pkg::PSW_TIMER_IRQ_ENABLE] <= 1'b0;
            processor_status_word[irqc_pkg::PSW_BUSY] <= 1'b0;
        end else begin
            if (wr_psw) begin
                processor_status_word[irqc_pkg::PSW_ENI] <= data_req.wdata[irqc_pkg::PSW_ENI];
                processor_status_word[irqc_pkg::PSW_TIMER_IRQ_ENABLE] <= data_req.wdata[irqc_pkg::PSW_TIMER_IRQ_ENABLE];
            end
            // Shifter finishing wins over software
            if (serial_busy_clr) begin
                processor_status_word[irqc_pkg::PSW_BUSY] <= 1'b0;
            end else if (serial_busy_set) begin
                processor_status_word[irqc_pkg::PSW_BUSY] <= 1'b1;
            end else if (wr_psw) begin
                processor_status_word[irqc_pkg::PSW_BUSY] <= data_req.wdata[irqc_pkg::PSW_BUSY];
            end
        end
    end

    // Carry and half carry update together; load takes each from its own input
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            processor_status_word[irqc_pkg::PSW_C] <= 1'b0;
            processor_status_word[irqc_pkg::PSW_HC] <= 1'b0;
        end else begin
            case (carry_op)
                irqc_pkg::IRQC_CY_SET: begin
                    processor_status_word[irqc_pkg::PSW_C] <= 1'b1;
                    processor_status_word[irqc_pkg::PSW_HC] <= 1'b1;
                end
                irqc_pkg::IRQC_CY_CLR: begin
                    processor_status_word[irqc_pkg::PSW_C] <= 1'b0;
                    processor_status_word[irqc_pkg::PSW_HC] <= 1'b0;
                end
                irqc_pkg::IRQC_CY_LOAD: begin
                    processor_status_word[irqc_pkg::PSW_C] <= carry_in;
                    processor_status_word[irqc_pkg::PSW_HC] <= half_in;
                end
                default: begin
                    if (wr_psw) begin
                        processor_status_word[irqc_pkg::PSW_C] <= data_req.wdata[irqc_pkg::PSW_C];
                        processor_status_word[irqc_pkg::PSW_HC] <= data_req.wdata[irqc_pkg::PSW_HC];
                    end
                end
            endcase
        end
    end

    // Plain storage registers
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            serial_shift_data <= irqc_pkg::RESET_REG;
            timer_count_low <= irqc_pkg::RESET_REG;
            timer_count_high <= irqc_pkg::RESET_REG;
            timer_reload_low <= irqc_pkg::RESET_REG;
            timer_reload_high <= irqc_pkg::RESET_REG;
            index_pointer_two <= irqc_pkg::RESET_REG;
            stack_pointer <= irqc_pkg::RESET_REG;
            index_pointer_one <= irqc_pkg::RESET_REG;
        end else if (data_req.wr) begin
            case (data_req.addr)
                irqc_pkg::OFF_SERIAL_SHIFT_DATA: serial_shift_data <= data_req.wdata;
                irqc_pkg::OFF_TIMER_COUNT_LOW: timer_count_low <= data_req.wdata;
                irqc_pkg::OFF_TIMER_COUNT_HIGH: timer_count_high <= data_req.wdata;
                irqc_pkg::OFF_TIMER_RELOAD_LOW: timer_reload_low <= data_req.wdata;
                irqc_pkg::OFF_TIMER_RELOAD_HIGH: timer_reload_high <= data_req.wdata;
                irqc_pkg::OFF_INDEX_POINTER_TWO: index_pointer_two <= data_req.wdata;
                irqc_pkg::OFF_STACK_POINTER: stack_pointer <= data_req.wdata;
                irqc_pkg::OFF_INDEX_POINTER_ONE: index_pointer_one <= data_req.wdata;
                default: serial_shift_data <= serial_shift_data;
            endcase
        end
    end

    // Data read mux, registered
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            data_rdata <= irqc_pkg::RESET_REG;
        end else if (data_req.rd) begin
            case (data_req.addr)
                irqc_pkg::OFF_SERIAL_SHIFT_DATA: data_rdata <= serial_shift_data;
                irqc_pkg::OFF_TIMER_COUNT_LOW: data_rdata <= timer_count_low;
                irqc_pkg::OFF_TIMER_COUNT_HIGH: data_rdata <= timer_count_high;
                irqc_pkg::OFF_TIMER_RELOAD_LOW: data_rdata <= timer_reload_low;
                irqc_pkg::OFF_TIMER_RELOAD_HIGH: data_rdata <= timer_reload_high;
                irqc_pkg::OFF_TIMER_SERIAL_CTRL: data_rdata <= ctrl;
                irqc_pkg::OFF_PROC_STATUS_WORD: data_rdata <= processor_status_word;
                irqc_pkg::OFF_INDEX_POINTER_TWO: data_rdata <= index_pointer_two;
                irqc_pkg::OFF_STACK_POINTER: data_rdata <= stack_pointer;
                irqc_pkg::OFF_INDEX_POINTER_ONE: data_rdata <= index_pointer_one;
                default: begin
                    if (data_req.addr < irqc_pkg::UNUSED_RAM_LO) begin
                        data_rdata <= ram_rdata;
                    end else if (data_req.addr <= irqc_pkg::UNUSED_RAM_HI) begin
                        data_rdata <= irqc_pkg::ALL_ONES;
                    end else if (data_req.addr >= 8'h00F0) begin
                        data_rdata <= ram_rdata;
                    end else begin
                        // Undefined space; zero chosen for determinism
                        data_rdata <= irqc_pkg::UNDEF_DATA;
                    end
                end
            endcase
        end
    end

    // Program read: unimplemented space forces the trap opcode
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rom_data_out <= irqc_pkg::TRAP_OPCODE;
        end else if (rom_addr >= irqc_pkg::PROG_LIMIT) begin
            rom_data_out <= irqc_pkg::TRAP_OPCODE;
        end else begin
            rom_data_out <= rom_rdata;
        end
    end

    // Vectoring; trap pushes the trapping opcode's address
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            vector_take <= 1'b0;
            vector_pc <= 15'h0000;
            push_req <= 1'b0;
            push_pc <= 15'h0000;
            trap_taken <= 1'b0;
        end else begin
            vector_take <= accept_hw | accept_trap;
            push_req <= accept_hw | accept_trap;
            trap_taken <= accept_trap;
            vector_pc <= irqc_pkg::IRQ_VECTOR;
            if (accept_trap) begin
                push_pc <= core_req.fetch_pc;
            end else if (accept_hw) begin
                push_pc <= core_req.stack_pc;
            end
        end
    end

    always_comb begin
        case (ctrl[irqc_pkg::CTL_DIV_HIGH:irqc_pkg::CTL_DIV_LOW])
            2'h0: serial_divide = irqc_pkg::DIV_BY_2;
            2'h1: serial_divide = irqc_pkg::DIV_BY_4;
            default: serial_divide = irqc_pkg::DIV_BY_8;
        endcase
    end

    assign timer_advance = ctrl[irqc_pkg::CTL_GO];
    assign timer_mode = ctrl[irqc_pkg::CTL_MODE_A:irqc_pkg::CTL_MODE_Z];
    assign serial_pins_on = ctrl[irqc_pkg::CTL_PINSEL];
    assign control_word = ctrl;
    assign status_word = processor_status_word;
endmodule // irqc_top

// File: test/irqc_checker_assertions.sv
// Concurrent checks on the ports of the interrupt and control block
`timescale 1ns/100ps
module irqc_checker (
    input wire logic                     sys_clk,
    input wire logic                     nrst,
    input wire irqc_pkg::irqc_core_req_t core_req,
    input wire irqc_pkg::irqc_data_req_t data_req,
    input wire logic [14:0]              rom_addr,
    input wire logic [7:0]               rom_data_out,
    input wire logic [7:0]               data_rdata,
    input wire logic                     vector_take,
    input wire logic [14:0]              vector_pc,
    input wire logic                     push_req,
    input wire logic [14:0]              push_pc,
    input wire logic                     trap_taken,
    input wire logic                     timer_advance,
    input wire logic [2:0]               timer_mode,
    input wire logic [3:0]               serial_divide,
    input wire logic                     serial_pins_on,
    input wire logic [7:0]               control_word,
    input wire logic [7:0]               status_word
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    logic hw_take;
    logic hw_ready;
    assign hw_take  = vector_take && !trap_taken;
    assign hw_ready = status_word[0] && (status_word[1] && status_word[3]
                      || status_word[4] && status_word[5]);
    a_vector_fixed: assert property (vector_take |-> vector_pc == 15'h00FF && push_req)
        else $error("vector taken without fixed target or push");
    a_hw_gie_clear: assert property (hw_take |-> !status_word[0])
        else $error("hardware entry left global enable set");
    a_hw_cause: assert property (hw_take |-> $past(core_req.boundary && hw_ready))
        else $error("hardware entry without boundary, enables and pending");
    a_hw_taken: assert property (core_req.boundary && hw_ready |-> ##1 hw_take)
        else $error("enabled pending request not taken at boundary");
    a_trap_cause: assert property (trap_taken |-> $past(core_req.fetch_valid)
        && $past(core_req.fetch_opcode) == 8'h00)
        else $error("trap without zero opcode fetch");
    a_trap_pc: assert property (trap_taken |-> vector_take && push_pc == $past(core_req.fetch_pc))
        else $error("trap saved wrong return address");
    a_trap_gie: assert property ($past(nrst) && trap_taken |-> $stable(status_word[0]))
        else $error("trap changed global enable");
    a_trap_last: assert property ($past(nrst) && trap_taken |->
        !$past(status_word[3]) && !$past(status_word[5]))
        else $error("trap taken while hardware pending");
    a_exit_gie: assert property ($past(core_req.irq_exit) && !vector_take |-> status_word[0])
        else $error("interrupt return did not set global enable");
    a_rom_limit: assert property ($past(rom_addr) >= 15'h0300 |-> rom_data_out == 8'h00)
        else $error("program byte past limit not zero");
    a_unused_ones: assert property ($past(data_req.rd) &&
        $past(data_req.addr) inside {[8'h30:8'h7F]} |-> data_rdata == 8'hFF)
        else $error("unused data read not all ones");
    a_pend_hold: assert property ($past(nrst) && $past(status_word[3]) &&
        !$past(data_req.wr) |-> status_word[3])
        else $error("external pending dropped without write");
    a_div_code: assert property (serial_divide ==
        (control_word[1] ? 4'h8 : control_word[0] ? 4'h4 : 4'h2))
        else $error("serial divide does not match code");
    a_ctl_fields: assert property ({timer_mode, timer_advance, serial_pins_on} ==
        control_word[7:3])
        else $error("control outputs do not follow control word");
    c_hw_entry: cover property (hw_take);
    c_trap_entry: cover property (trap_taken);
    c_timer_pend: cover property ($rose(status_word[5]));
endmodule // irqc_checker

bind irqc_top irqc_checker i_irqc_checker (
    .sys_clk, .nrst, .core_req, .data_req, .rom_addr, .rom_data_out, .data_rdata,
    .vector_take, .vector_pc, .push_req, .push_pc, .trap_taken, .timer_advance,
    .timer_mode, .serial_divide, .serial_pins_on, .control_word, .status_word
);

// File: test/irqc_mem_model.sv
// Program and RAM model behind the block
`timescale 1ns/100ps
module irqc_mem_model (
    input wire logic                     sys_clk,
    input wire irqc_pkg::irqc_data_req_t data_req,
    input wire logic [14:0]              rom_addr,
    output logic [7:0]                   ram_rdata,
    output logic [7:0]                   rom_rdata
);
    logic [7:0] ram [256];
    // Raw bytes exist past the limit too; zeroing them is the block's job
    assign rom_rdata = rom_addr[7:0] ^ 8'h5A;
    assign ram_rdata = ram[data_req.addr];
    always_ff @(posedge sys_clk) begin
        if (data_req.wr) begin
            ram[data_req.addr] <= data_req.wdata;
        end
    end
endmodule // irqc_mem_model

// File: test/irqc_top_bench.sv
// Self-checking bench for the interrupt and control block
`timescale 1ns/100ps
module irqc_top_bench;
    logic                     sys_clk;
    logic                     nrst;
    irqc_pkg::irqc_core_req_t core_req;
    irqc_pkg::irqc_data_req_t data_req;
    irqc_pkg::irqc_cy_op_t    carry_op;
    logic [7:0]               ram_rdata, rom_rdata, rom_data_out, data_rdata;
    logic [7:0]               control_word, status_word;
    logic [14:0]              rom_addr, vector_pc, push_pc;
    logic                     ext_irq_pin, timer_underflow, timer_capture;
    logic                     serial_busy_set, serial_busy_clr, carry_in, half_in;
    logic                     vector_take, push_req, trap_taken, timer_advance;
    logic                     serial_pins_on;
    logic [2:0]               timer_mode;
    logic [3:0]               serial_divide;
    logic [3:0]               div_exp [4];
    int                       err_total;
    int                       num_checks;

    irqc_top i_irqc_top (
        .sys_clk, .nrst, .core_req, .data_req, .ram_rdata, .rom_rdata, .rom_addr,
        .ext_irq_pin, .timer_underflow, .timer_capture, .serial_busy_set,
        .serial_busy_clr, .carry_op, .carry_in, .half_in, .rom_data_out, .data_rdata,
        .vector_take, .vector_pc, .push_req, .push_pc, .trap_taken, .timer_advance,
        .timer_mode, .serial_divide, .serial_pins_on, .control_word, .status_word
    );
    irqc_mem_model i_irqc_mem_model (.sys_clk, .data_req, .rom_addr, .ram_rdata, .rom_rdata);

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Strobes drop for a cycle so back-to-back calls never re-drive in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        data_req = '{1'b0, 1'b1, a, d};
        tick(1);
        data_req = '0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        data_req = '{1'b1, 1'b0, a, 8'h00};
        tick(1);
        data_req = '0;
        tick(1);
        chk(data_rdata, exp);
    endtask
    // Entry pulses stand one cycle, so callers check right after
    task automatic step(input logic b, input logic f, input logic x);
        core_req.boundary = b;
        core_req.fetch_valid = f;
        core_req.irq_exit = x;
        tick(1);
        core_req.boundary = 1'b0;
        core_req.fetch_valid = 1'b0;
        core_req.irq_exit = 1'b0;
    endtask
    task automatic pin(input logic v);
        ext_irq_pin = v;
        tick(6);
    endtask
    task automatic tpulse(input logic cap);
        timer_capture = cap;
        timer_underflow = !cap;
        tick(1);
        timer_capture = 1'b0;
        timer_underflow = 1'b0;
    endtask
    task automatic romchk(input logic [14:0] a, input logic [7:0] exp);
        rom_addr = a;
        tick(2);
        chk(rom_data_out, exp);
    endtask
    task automatic cy(input irqc_pkg::irqc_cy_op_t op, input logic c, input logic [7:0] exp);
        carry_op = op;
        carry_in = c;
        half_in = !c;
        tick(1);
        carry_op = irqc_pkg::IRQC_CY_NONE;
        rd(8'hEF, exp);
    endtask
    task automatic summarize();
        if (err_total == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Sequence needs under 150 cycles; this leaves ample margin
    initial begin
        repeat (3000) @(posedge sys_clk);
        err_total++;
        summarize();
    end

    initial begin
        err_total = 0;
        num_checks = 0;
        nrst = 1'b0;
        core_req = '{1'b0, 1'b0, 8'h00, 15'h0456, 1'b0, 15'h1234};
        data_req = '0;
        rom_addr = 15'h0000;
        carry_op = irqc_pkg::IRQC_CY_NONE;
        div_exp = '{4'h2, 4'h4, 4'h8, 4'h8};
        {ext_irq_pin, timer_underflow, timer_capture, serial_busy_set} = '0;
        {serial_busy_clr, carry_in, half_in} = '0;
        tick(10);
        nrst = 1'b1;
        rd(8'hEE, 8'h00);
        rd(8'hEF, 8'h00);
        wr(8'hEE, 8'hD5);
        chk(timer_mode, 3'h6);
        chk(timer_advance, 1'b1);
        chk(control_word, 8'hD5);
        for (int i = 0; i < 4; i++) begin
            wr(8'hEE, 8'h08 | 8'(i));
            chk(serial_divide, div_exp[i]);
            chk({serial_pins_on, timer_advance}, 2'h2);
        end
        wr(8'h10, 8'h3C);
        rd(8'h10, 8'h3C);
        rd(8'h30, 8'hFF);
        rd(8'h7F, 8'hFF);
        rd(8'h80, irqc_pkg::UNDEF_DATA);
        romchk(15'h02FF, 8'hA5);
        romchk(15'h0300, 8'h00);
        romchk(15'h04FF, 8'h00);
        wr(8'hEE, 8'h04);
        pin(1'b1);
        rd(8'hEF, 8'h08);
        wr(8'hEF, 8'h00);
        pin(1'b0);
        rd(8'hEF, 8'h00);
        wr(8'hEE, 8'h00);
        pin(1'b1);
        rd(8'hEF, 8'h00);
        pin(1'b0);
        rd(8'hEF, 8'h08);
        wr(8'hEF, 8'h0B);
        step(1'b1, 1'b0, 1'b0);
        chk({vector_take, push_req, trap_taken}, 3'h6);
        chk(push_pc, 15'h1234);
        chk(vector_pc, irqc_pkg::IRQ_VECTOR);
        rd(8'hEF, 8'h0A);
        step(1'b0, 1'b0, 1'b1);
        rd(8'hEF, 8'h0B);
        data_req = '{1'b0, 1'b1, 8'hEF, 8'h09};
        step(1'b1, 1'b0, 1'b0);
        chk(vector_take, 1'b1);
        wr(8'hEF, 8'h09);
        step(1'b1, 1'b0, 1'b0);
        chk(vector_take, 1'b0);
        tick(1);
        step(1'b0, 1'b1, 1'b0);
        chk(vector_take, 1'b0);
        wr(8'hEF, 8'h0B);
        step(1'b1, 1'b1, 1'b0);
        chk({vector_take, trap_taken}, 2'h2);
        chk(push_pc, 15'h1234);
        wr(8'hEF, 8'h01);
        step(1'b0, 1'b1, 1'b0);
        chk({vector_take, trap_taken}, 2'h3);
        chk(push_pc, 15'h0456);
        rd(8'hEF, 8'h01);
        core_req.fetch_opcode = 8'h01;
        step(1'b0, 1'b1, 1'b0);
        chk(vector_take, 1'b0);
        wr(8'hEE, 8'h80);
        tpulse(1'b0);
        rd(8'hEF, 8'h21);
        wr(8'hEF, 8'h01);
        wr(8'hEE, 8'hC0);
        tpulse(1'b0);
        rd(8'hEF, 8'h01);
        tpulse(1'b1);
        rd(8'hEF, 8'h21);
        wr(8'hEF, 8'h31);
        step(1'b1, 1'b0, 1'b0);
        chk(vector_take, 1'b1);
        rd(8'hEF, 8'h30);
        cy(irqc_pkg::IRQC_CY_SET, 1'b0, 8'hF0);
        cy(irqc_pkg::IRQC_CY_CLR, 1'b0, 8'h30);
        cy(irqc_pkg::IRQC_CY_LOAD, 1'b1, 8'h70);
        serial_busy_set = 1'b1;
        tick(1);
        serial_busy_set = 1'b0;
        chk(status_word, 8'h74);
        serial_busy_clr = 1'b1;
        tick(1);
        serial_busy_clr = 1'b0;
        rd(8'hEF, 8'h70);
        summarize();
    end
endmodule // irqc_top_bench
